// [cdsc_pkg.sv]
/*
  Shared constants and carrier types for the counter display status block.
  Assumes a 10 MHz timebase and an APB master with 32-bit data.
*/
`default_nettype none
package cdsc_pkg;
  // ==========================================================================
  // Timebase
  localparam int unsigned CLK_HZ = 10_000_000;
  localparam int unsigned ONESHOT_MS = 40;
  localparam int unsigned ONESHOT_CYC = CLK_HZ / 1000 * ONESHOT_MS;
  localparam int unsigned POWER_LT_S = 2;
  localparam int unsigned POWER_LT_CYC = CLK_HZ * POWER_LT_S;
  localparam int unsigned MIN_GATE_NS = 50;
  localparam int unsigned MIN_GATE_CYC = (MIN_GATE_NS * (CLK_HZ / 1_000_000) + 999) / 1000;
  localparam int unsigned RATE_STEP_MS = 100;
  localparam int unsigned RATE_STEP_CYC = CLK_HZ / 1000 * RATE_STEP_MS;
  localparam int unsigned DETENT_LT_CYC = 16;
  localparam int unsigned TIMEOUT_FLASH_CYC = 8;
  // ==========================================================================
  // Display geometry
  localparam int unsigned DATA_DIGITS = 11;
  localparam int unsigned DISP_POSITIONS = DATA_DIGITS + 1;
  localparam int unsigned CNT_W = 40;
  // ==========================================================================
  // Register map (byte addresses)
  localparam logic [7:0] CTRL_ADDR = 8'h00;
  localparam logic [7:0] STATUS_ADDR = 8'h04;
  localparam logic [7:0] RESULT_LO_ADDR = 8'h08;
  localparam logic [7:0] RESULT_HI_ADDR = 8'h0C;
  // CTRL fields
  localparam int unsigned FUNC_LSB = 0;
  localparam int unsigned WIN_LSB = 4;
  localparam int unsigned POS_LSB = 8;
  localparam int unsigned RATE_LSB = 12;
  localparam int unsigned ACCUM_LSB = 18;
  localparam int unsigned CHECK_BIT = 20;
  localparam int unsigned SHARED_BIT = 21;
  localparam int unsigned EXTREF_BIT = 22;
  localparam logic [31:0] CTRL_RESET = 32'h0000_0011;
  // STATUS bits
  localparam int unsigned ST_ASTERISK = 0;
  localparam int unsigned ST_OVER = 1;
  localparam int unsigned ST_UNDER = 2;
  localparam int unsigned ST_FILLER = 3;
  localparam int unsigned ST_OVEN = 4;
  localparam int unsigned ST_ARM = 5;
  localparam int unsigned ST_GATE = 6;
  localparam int unsigned ST_LAMP = 7;
  localparam int unsigned ST_MINUS = 8;
  // ==========================================================================
  // Encodings
  typedef enum logic [2:0] {
    FN_FREQ = 3'h0, FN_PERIOD = 3'h1, FN_INTERVAL = 3'h2, FN_RATIO = 3'h3,
    FN_TOT_START = 3'h4, FN_TOT_STOP = 3'h5
  } cdsc_func_e;
  typedef enum logic [1:0] {ACC_A = 2'h0, ACC_DIFF = 2'h1, ACC_SUM = 2'h2} cdsc_accum_e;
  typedef struct packed {
    logic lamp_all;
    logic minus;
    logic [DATA_DIGITS-1:0] dp;
    logic [3:0] annun;
    logic [CNT_W-1:0] value;
  } cdsc_disp_s;
endpackage
`default_nettype wire

// [cdsc_sync.sv]
/*
  Two-stage synchroniser for a group of pin levels.
  Assumes inputs are asynchronous levels with no timing relation to clk.
*/
`timescale 1ns/1ps
`default_nettype none
module cdsc_sync #(
  parameter int unsigned W = 1
) (
  input wire logic sys_clk_i, // Timebase
  input wire logic rst_n_i, // Async reset
  input wire logic [W-1:0] d_i, // Pin levels
  output logic [W-1:0] q_o // Synchronised levels
);
  logic [W-1:0] meta_r;
  always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      meta_r <= '0;
      q_o <= '0;
    end else begin
      meta_r <= d_i;
      q_o <= meta_r;
    end
  end
endmodule // cdsc_sync
`default_nettype wire

// [cdsc_oneshot.sv]
/*
  Retriggerable pulse stretcher: output holds while trigger is high and
  for LEN cycles after it falls. Assumes trigger is synchronous.
*/
`timescale 1ns/1ps
`default_nettype none
module cdsc_oneshot #(
  parameter int unsigned LEN = 400_000
) (
  input wire logic sys_clk_i, // Timebase
  input wire logic rst_n_i, // Async reset
  input wire logic trig_i, // Level to stretch
  output logic out_o // Stretched level
);
  logic [31:0] cnt_r;
  always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      cnt_r <= '0;
    end else if (trig_i) begin
      cnt_r <= LEN;
    end else if (cnt_r != '0) begin
      cnt_r <= cnt_r - 32'd1;
    end
  end
  assign out_o = trig_i || (cnt_r != '0);
endmodule // cdsc_oneshot
`default_nettype wire

// [cdsc_core.sv]
/*
  Front-panel status and control logic of a bench frequency counter:
  measurement sequencing, lamps, asterisk flags, lamp test and display data.
  Assumes a 10 MHz timebase, APB register access, and pins that are
  asynchronous to the timebase and slower than half its rate.
*/
// Design decisions made here: the APB slave port and the address map.
`timescale 1ns/1ps
`default_nettype none
module cdsc_core #(
  parameter int unsigned ONESHOT_CYC = cdsc_pkg::ONESHOT_CYC,
  parameter int unsigned POWER_LT_CYC = cdsc_pkg::POWER_LT_CYC,
  parameter int unsigned RATE_STEP_CYC = cdsc_pkg::RATE_STEP_CYC
) (
  input wire logic sys_clk_i, // 10 MHz timebase
  input wire logic rst_n_i, // Async reset, active low
  input wire logic psel, // APB select
  input wire logic penable, // APB access phase
  input wire logic pwrite, // APB direction
  input wire logic [7:0] paddr, // APB byte address
  input wire logic [31:0] pwdata, // APB write data
  output logic [31:0] prdata, // APB read data
  output logic pready, // APB ready
  output logic pslverr, // APB error
  input wire logic chan_a_i, // First channel trigger pin
  input wire logic chan_b_i, // Second channel trigger pin
  input wire logic test_sig_i, // Internal check signal
  input wire logic oven_cold_i, // Oven below operating range
  input wire logic oven_fitted_i, // Unit has oven oscillator
  input wire logic reset_btn_i, // Reset button pressed
  input wire logic power_on_i, // Power switch in on position
  input wire logic ref_locking_i, // Locking to external reference
  input wire logic ref_lost_i, // External reference missing
  output cdsc_pkg::cdsc_disp_s disp_o, // Display data, 12 positions
  output logic asterisk_o, // Asterisk lamp
  output logic arm_lamp_o, // Armed-wait lamp
  output logic gate_lamp_o, // Gate-open lamp
  output logic scaled_o, // Scaled first-channel output
  output logic ext_ref_sel_o // External reference selected
);
  localparam int unsigned W = cdsc_pkg::CNT_W;
  // ==========================================================================
  // Helpers
  function automatic logic [W-1:0] pow10(input logic [3:0] n);
    logic [W-1:0] p;
    p = W'(1);
    for (int i = 0; i < 15; i++) begin
      if (i < int'(n)) p = W'(p * W'(10));
    end
    return p;
  endfunction
  function automatic logic rise(input logic now, input logic was);
    return now && !was;
  endfunction

  typedef enum logic [3:0] {
    ST_ARM = 4'b0001, ST_GATE = 4'b0010, ST_TAIL = 4'b0100, ST_SHOW = 4'b1000
  } cdsc_state_e;
  // ==========================================================================
  // Pin synchronisers
  logic [7:0] pin_s;
  logic [7:0] pin_d_r;
  cdsc_sync #(.W(8)) u_sync (
    .sys_clk_i(sys_clk_i),
    .rst_n_i(rst_n_i),
    .d_i({chan_a_i, chan_b_i, test_sig_i, oven_cold_i, reset_btn_i, power_on_i,
          ref_locking_i, ref_lost_i}),
    .q_o(pin_s)
  );
  always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) pin_d_r <= '0;
    else pin_d_r <= pin_s;
  end
  logic a_lvl, b_lvl, t_lvl, oven_s, btn_s, pwr_s, lock_s, lost_s;
  assign {a_lvl, b_lvl, t_lvl, oven_s, btn_s, pwr_s, lock_s, lost_s} = pin_s;
  // ==========================================================================
  // Control register
  logic [31:0] ctrl_r;
  logic wr_en;
  cdsc_pkg::cdsc_func_e func;
  cdsc_pkg::cdsc_accum_e accum;
  logic [3:0] win_idx, pos_sel;
  logic [5:0] rate;
  logic check_en, ext_sel;
  assign wr_en = psel && penable && pwrite;
  assign func = cdsc_pkg::cdsc_func_e'(ctrl_r[cdsc_pkg::FUNC_LSB +: 3]);
  assign win_idx = ctrl_r[cdsc_pkg::WIN_LSB +: 4];
  assign pos_sel = ctrl_r[cdsc_pkg::POS_LSB +: 4];
  assign rate = ctrl_r[cdsc_pkg::RATE_LSB +: 6];
  assign accum = cdsc_pkg::cdsc_accum_e'(ctrl_r[cdsc_pkg::ACCUM_LSB +: 2]);
  assign check_en = ctrl_r[cdsc_pkg::CHECK_BIT];
  assign ext_sel = ctrl_r[cdsc_pkg::EXTREF_BIT];
  assign ext_ref_sel_o = ext_sel;

  logic detent_move;
  always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      ctrl_r <= cdsc_pkg::CTRL_RESET;
      detent_move <= 1'b0;
    end else begin
      detent_move <= 1'b0;
      if (wr_en && paddr == cdsc_pkg::CTRL_ADDR) begin
        ctrl_r <= pwdata;
        detent_move <= (pwdata[11:0] != ctrl_r[11:0]);
      end
    end
  end
  // ==========================================================================
  // Input routing
  logic a_in, b_in, a_ev, b_ev, a_prev_r, b_prev_r;
  always_comb begin
    a_in = check_en ? t_lvl : a_lvl;
    b_in = check_en ? t_lvl : (ctrl_r[cdsc_pkg::SHARED_BIT] ? a_lvl : b_lvl);
  end
  always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      a_prev_r <= 1'b0;
      b_prev_r <= 1'b0;
    end else begin
      a_prev_r <= a_in;
      b_prev_r <= b_in;
    end
  end
  assign a_ev = rise(a_in, a_prev_r);
  assign b_ev = rise(b_in, b_prev_r);
  // ==========================================================================
  // Lamp test sources
  logic btn_ev, pwr_ev, lamp_test;
  logic [31:0] pwr_cnt_r;
  logic [7:0] move_cnt_r, flash_cnt_r;
  logic timeout_ev;
  assign btn_ev = rise(btn_s, pin_d_r[3]);
  assign pwr_ev = rise(pwr_s, pin_d_r[2]);
  always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) pwr_cnt_r <= '0;
    else if (pwr_ev) pwr_cnt_r <= POWER_LT_CYC;
    else if (pwr_cnt_r != '0) pwr_cnt_r <= pwr_cnt_r - 32'd1;
  end
  always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) move_cnt_r <= '0;
    else if (detent_move) move_cnt_r <= 8'(cdsc_pkg::DETENT_LT_CYC);
    else if (move_cnt_r != '0) move_cnt_r <= move_cnt_r - 8'd1;
  end
  always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) flash_cnt_r <= '0;
    else if (timeout_ev) flash_cnt_r <= 8'(cdsc_pkg::TIMEOUT_FLASH_CYC);
    else if (flash_cnt_r != '0) flash_cnt_r <= flash_cnt_r - 8'd1;
  end
  assign lamp_test = btn_s || (pwr_cnt_r != '0) || (move_cnt_r != '0) || lock_s
                   || (flash_cnt_r != '0) || (ext_sel && lost_s);
  // ==========================================================================
  // Measurement sequencer
  cdsc_state_e state_r;
  logic [W-1:0] win_cyc, cnt_r, tmr_r, res_r;
  logic res_neg_r, gate_open, totalize, restart;
  logic [31:0] rate_cnt_r;
  assign win_cyc = (win_idx == 4'd0) ? W'(cdsc_pkg::MIN_GATE_CYC) : pow10(win_idx - 4'd1);
  assign totalize = (func == cdsc_pkg::FN_TOT_START) || (func == cdsc_pkg::FN_TOT_STOP);
  assign restart = btn_ev || detent_move;
  assign gate_open = (state_r == ST_GATE) || (state_r == ST_TAIL);

  logic gate_done, tail_done;
  always_comb begin
    gate_done = (tmr_r + W'(1) >= win_cyc);
    unique case (func)
      cdsc_pkg::FN_INTERVAL: tail_done = b_ev;
      cdsc_pkg::FN_RATIO: tail_done = 1'b1;
      default: tail_done = a_ev;
    endcase
    if (func == cdsc_pkg::FN_RATIO) gate_done = (tmr_r + W'(1) >= win_cyc) && a_ev;
    if (func == cdsc_pkg::FN_INTERVAL) gate_done = 1'b1;
  end
  assign timeout_ev = (state_r == ST_TAIL) && !tail_done
                    && (tmr_r >= (win_cyc << 1) + win_cyc + (win_cyc >> 1));

  always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      state_r <= ST_ARM;
      tmr_r <= '0;
      rate_cnt_r <= '0;
    end else if (restart || timeout_ev || totalize) begin
      state_r <= ST_ARM;
      tmr_r <= '0;
      rate_cnt_r <= '0;
    end else begin
      unique case (state_r)
        ST_ARM: begin
          tmr_r <= '0;
          if (a_ev) state_r <= ST_GATE;
        end
        ST_GATE: begin
          tmr_r <= tmr_r + W'(1);
          if (gate_done) begin
            state_r <= ST_TAIL;
            tmr_r <= '0;
          end
        end
        ST_TAIL: begin
          tmr_r <= tmr_r + W'(1);
          if (tail_done) begin
            state_r <= ST_SHOW;
            rate_cnt_r <= 32'(rate) * RATE_STEP_CYC;
          end
        end
        ST_SHOW: begin
          if (rate != 6'd0) begin
            if (rate_cnt_r == '0) state_r <= ST_ARM;
            else rate_cnt_r <= rate_cnt_r - 32'd1;
          end
        end
      endcase
    end
  end
  // ==========================================================================
  // Counting and result
  logic tot_gate, signed_neg;
  assign tot_gate = (func == cdsc_pkg::FN_TOT_START);
  always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      cnt_r <= '0;
      res_neg_r <= 1'b0;
    end else if (restart) begin
      cnt_r <= '0;
      res_neg_r <= 1'b0;
    end else if (totalize) begin
      if (tot_gate) begin
        unique case (accum)
          cdsc_pkg::ACC_DIFF: cnt_r <= cnt_r + W'(a_ev) - W'(b_ev);
          cdsc_pkg::ACC_SUM: cnt_r <= cnt_r + W'(a_ev) + W'(b_ev);
          default: cnt_r <= cnt_r + W'(a_ev);
        endcase
      end
    end else if (state_r == ST_ARM) begin
      cnt_r <= '0;
    end else if (gate_open) begin
      unique case (func)
        cdsc_pkg::FN_FREQ: cnt_r <= cnt_r + W'(a_ev);
        cdsc_pkg::FN_RATIO: cnt_r <= cnt_r + W'(b_ev);
        default: cnt_r <= cnt_r + W'(1);
      endcase
    end
  end
  assign signed_neg = cnt_r[W-1] && totalize && (accum == cdsc_pkg::ACC_DIFF);

  logic meas_end;
  assign meas_end = (state_r == ST_TAIL) && tail_done && !timeout_ev && !restart;
  always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      res_r <= '0;
    end else if (restart || timeout_ev) begin
      res_r <= '0;
    end else if (totalize) begin
      res_r <= signed_neg ? W'(-cnt_r) : cnt_r;
    end else if (meas_end) begin
      res_r <= cnt_r;
    end
  end
  // ==========================================================================
  // Scaled output
  logic [W-1:0] scale_cnt_r;
  logic scaled_r;
  always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      scale_cnt_r <= '0;
      scaled_r <= 1'b0;
    end else if (tot_gate && rate == 6'd0) begin
      if (a_ev) begin
        if (scale_cnt_r + W'(1) >= (pow10(win_idx + 4'd1) >> 1)) begin
          scale_cnt_r <= '0;
          scaled_r <= !scaled_r;
        end else begin
          scale_cnt_r <= scale_cnt_r + W'(1);
        end
      end
    end else begin
      scale_cnt_r <= '0;
      scaled_r <= 1'b0;
    end
  end
  assign scaled_o = scaled_r;
  // ==========================================================================
  // Display placement and asterisk
  logic auto_pos, over, under, filler;
  logic [4:0] ndig;
  logic signed [5:0] shift;
  logic [3:0] annun_r;
  assign auto_pos = (pos_sel == 4'd0);
  assign ndig = 5'(win_idx) + 5'd1;
  assign shift = auto_pos ? 6'sd0 : 6'(signed'({2'b00, pos_sel})) - 6'sd6;
  assign over = !auto_pos && (7'(signed'(shift)) + signed'(7'(ndig)) > 7'sd11);
  assign under = !auto_pos && (shift < 6'sd0);
  assign filler = !auto_pos && (shift > 6'sd0) && (7'(ndig) <= 7'(signed'(shift)));
  always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) annun_r <= '0;
    else if (restart || (auto_pos && meas_end)) annun_r <= win_idx;
  end
  assign asterisk_o = over || under || filler || (oven_fitted_i && oven_s);

  cdsc_pkg::cdsc_disp_s disp_r;
  always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      disp_r <= '0;
    end else if (lamp_test) begin
      disp_r <= '{lamp_all: 1'b1, minus: 1'b1, dp: '1, annun: annun_r,
                  value: res_r};
    end else begin
      disp_r.lamp_all <= 1'b0;
      disp_r.minus <= signed_neg;
      disp_r.dp <= auto_pos ? 11'(1) : 11'(1) << (5'(pos_sel) - 5'd1);
      disp_r.annun <= annun_r;
      disp_r.value <= res_r;
    end
  end
  assign disp_o = disp_r;
  // ==========================================================================
  // Lamps
  logic gate_stretch;
  cdsc_oneshot #(.LEN(ONESHOT_CYC)) u_gate_os (
    .sys_clk_i(sys_clk_i),
    .rst_n_i(rst_n_i),
    .trig_i(gate_open || tot_gate),
    .out_o(gate_stretch)
  );
  assign gate_lamp_o = gate_stretch;
  assign arm_lamp_o = (state_r == ST_ARM) && !totalize;
  // ==========================================================================
  // APB slave
  logic [31:0] status;
  assign status = {23'd0, signed_neg, lamp_test, gate_lamp_o, arm_lamp_o,
                   oven_fitted_i && oven_s, filler, under, over, asterisk_o};
  assign pready = 1'b1;
  always_comb begin
    prdata = '0;
    pslverr = 1'b0;
    if (psel && penable) begin
      unique case (paddr)
        cdsc_pkg::CTRL_ADDR: prdata = ctrl_r;
        cdsc_pkg::STATUS_ADDR: prdata = status;
        cdsc_pkg::RESULT_LO_ADDR: prdata = res_r[31:0];
        cdsc_pkg::RESULT_HI_ADDR: prdata = {24'd0, res_r[W-1:32]};
        default: pslverr = 1'b1;
      endcase
    end
  end
endmodule // cdsc_core
`default_nettype wire

// [cdsc_chk.sv]
/* Port checker for cdsc_core: lamps, asterisk and lamp-test timing.
   Assumes one clock domain and pins held stable for several cycles. */
`timescale 1ns/1ps
`default_nettype none
module cdsc_chk #(
  parameter int unsigned ONESHOT_CYC = 20
) (
  input wire logic sys_clk_i, // Timebase
  input wire logic rst_n_i, // Async reset
  input wire logic psel, // APB select
  input wire logic penable, // APB access
  input wire logic pwrite, // APB direction
  input wire logic [7:0] paddr, // APB address
  input wire logic [31:0] pwdata, // APB write data
  input wire logic oven_cold_i, // Cold oven
  input wire logic oven_fitted_i, // Oven fitted
  input wire logic reset_btn_i, // Reset button
  input wire logic power_on_i, // Power switch
  input wire logic ref_locking_i, // Locking
  input wire logic ref_lost_i, // Reference lost
  input wire cdsc_pkg::cdsc_disp_s disp_o, // Display
  input wire logic asterisk_o, // Asterisk
  input wire logic arm_lamp_o, // Arm lamp
  input wire logic gate_lamp_o, // Gate lamp
  input wire logic ext_ref_sel_o // Ext reference select
);
  // ==========================================================================
  // Helper
  int unsigned hi_cnt;
  always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      hi_cnt <= 0;
    end else begin
      hi_cnt <= gate_lamp_o ? hi_cnt + 1 : 0;
    end
  end
  // ==========================================================================
  // Properties
  default clocking cb @(posedge sys_clk_i); endclocking
  default disable iff (!rst_n_i);
  sequence s_ctrl_wr;
    psel && penable && pwrite && paddr == cdsc_pkg::CTRL_ADDR;
  endsequence
  sequence s_power_up;
    $rose(power_on_i) ##1 power_on_i [*4];
  endsequence
  chk_oven_asterisk: assert property ((oven_fitted_i && oven_cold_i) [*4] |-> asterisk_o)
    else $error("asterisk dark with cold oven");
  chk_button_lamp: assert property (reset_btn_i [*4] |-> disp_o.lamp_all)
    else $error("no lamp test on button");
  chk_lock_lamp: assert property (ref_locking_i [*4] |-> disp_o.lamp_all)
    else $error("no lamp test while locking");
  chk_lost_lamp: assert property ((ext_ref_sel_o && ref_lost_i) [*4] |-> disp_o.lamp_all)
    else $error("no lamp test on lost reference");
  chk_lamp_face: assert property (disp_o.lamp_all |-> disp_o.minus && (&disp_o.dp))
    else $error("lamp test missing minus or points");
  chk_arm_to_gate: assert property ($fell(arm_lamp_o) |-> ##[0:2] gate_lamp_o)
    else $error("gate lamp not lit after arm");
  chk_gate_stretch: assert property ($fell(gate_lamp_o) |-> hi_cnt >= ONESHOT_CYC)
    else $error("gate lamp flash too short");
  chk_power_lamp: assert property (s_power_up |-> ##2 disp_o.lamp_all [*8])
    else $error("no lamp test after power on");
  chk_ext_select: assert property (s_ctrl_wr |=> ext_ref_sel_o == $past(pwdata[22]))
    else $error("reference select not taken");
endmodule // cdsc_chk
bind cdsc_core cdsc_chk #(.ONESHOT_CYC(ONESHOT_CYC)) i_cdsc_chk (
  .sys_clk_i(sys_clk_i), .rst_n_i(rst_n_i), .psel(psel), .penable(penable),
  .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .oven_cold_i(oven_cold_i),
  .oven_fitted_i(oven_fitted_i), .reset_btn_i(reset_btn_i), .power_on_i(power_on_i),
  .ref_locking_i(ref_locking_i), .ref_lost_i(ref_lost_i), .disp_o(disp_o),
  .asterisk_o(asterisk_o), .arm_lamp_o(arm_lamp_o), .gate_lamp_o(gate_lamp_o),
  .ext_ref_sel_o(ext_ref_sel_o));
`default_nettype wire

// [cdsc_panel.sv]
/* Front-panel partner: channel A trigger pin and check oscillator.
   Assumes requests are one-cycle strobes from the bench. */
`timescale 1ns/1ps
`default_nettype none
module cdsc_panel (
  input wire logic sys_clk_i, // Timebase
  input wire logic fire_a_i, // One channel A trigger
  input wire logic check_i, // Run check oscillator
  output logic chan_a_o, // Channel A pin
  output logic test_sig_o // Check signal pin
);
  logic [3:0] a_cnt = 4'h0;
  logic [2:0] t_cnt = 3'h0;
  // Each high level lasts four cycles so the pin sync never misses it
  always_ff @(posedge sys_clk_i) begin
    a_cnt <= fire_a_i ? 4'h8 : (a_cnt == 4'h0 ? 4'h0 : a_cnt - 4'h1);
    t_cnt <= t_cnt + 3'h1;
  end
  assign chan_a_o = a_cnt > 4'h4;
  assign test_sig_o = check_i & t_cnt[2];
endmodule // cdsc_panel
`default_nettype wire

// [counter_display_status_control_tb.sv]
/* Self-checking bench for cdsc_core over APB and panel pins.
   Assumes cdsc_pkg, cdsc_panel and the bound checker are compiled. */
`timescale 1ns/1ps
`default_nettype none
module counter_display_status_control_tb;
  logic sys_clk_i = 1'h0, rst_n_i = 1'h0, psel = 1'h0, penable = 1'h0, pwrite = 1'h0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0000_0000, prdata, rd;
  logic pready, pslverr, err, chan_a_i, test_sig_i, asterisk_o, arm_lamp_o, gate_lamp_o;
  logic oven_cold_i = 1'h0, oven_fitted_i = 1'h0, reset_btn_i = 1'h0, power_on_i = 1'h0;
  logic ref_locking_i = 1'h0, ref_lost_i = 1'h0, fire_a = 1'h0, check = 1'h0;
  logic chan_b_i = 1'h0, ext_ref_sel_o;
  cdsc_pkg::cdsc_disp_s disp_o;
  int n_errors = 0;
  int cmp_count = 0;
  localparam logic [3:0] WIN [5] = '{4'h1, 4'h1, 4'h4, 4'h1, 4'h0};
  localparam logic [3:0] POS [5] = '{4'h1, 4'hF, 4'hF, 4'h6, 4'h7};
  localparam logic [31:0] FLG [5] = '{32'h5, 32'h9, 32'hB, 32'h0, 32'h9};
  localparam logic [7:0] ST = cdsc_pkg::STATUS_ADDR;
  cdsc_core #(.ONESHOT_CYC(20), .POWER_LT_CYC(50), .RATE_STEP_CYC(10)) i_cdsc_core (
    .sys_clk_i(sys_clk_i), .rst_n_i(rst_n_i), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .chan_a_i(chan_a_i), .chan_b_i(chan_b_i), .test_sig_i(test_sig_i),
    .oven_cold_i(oven_cold_i), .oven_fitted_i(oven_fitted_i), .reset_btn_i(reset_btn_i),
    .power_on_i(power_on_i), .ref_locking_i(ref_locking_i), .ref_lost_i(ref_lost_i),
    .disp_o(disp_o), .asterisk_o(asterisk_o), .arm_lamp_o(arm_lamp_o),
    .gate_lamp_o(gate_lamp_o), .scaled_o(), .ext_ref_sel_o(ext_ref_sel_o));
  cdsc_panel i_cdsc_panel (.sys_clk_i(sys_clk_i), .fire_a_i(fire_a), .check_i(check),
    .chan_a_o(chan_a_i), .test_sig_o(test_sig_i));
  initial begin
    forever #50 sys_clk_i = ~sys_clk_i;
  end
  // ==========================================================================
  // Tasks
  task automatic tick(input int n);
    repeat (n) @(posedge sys_clk_i);
  endtask
  task automatic check_eq(input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      n_errors++;
      $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  // Starts after an edge so back-to-back calls never drive psel twice at once
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    @(posedge sys_clk_i);
    psel <= 1'h1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge sys_clk_i);
    penable <= 1'h1;
    @(posedge sys_clk_i);
    while (pready !== 1'h1) @(posedge sys_clk_i);
    rd = prdata;
    err = pslverr;
    psel <= 1'h0;
    penable <= 1'h0;
  endtask
  task automatic rd_chk(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
    apb(1'h0, a, 32'h0000_0000);
    check_eq(rd & m, e);
  endtask
  task automatic pulse_a;
    fire_a <= 1'h1;
    tick(1);
    fire_a <= 1'h0;
    tick(6);
  endtask
  task automatic wrap_up;
    $display("comparisons %0d mismatches %0d", cmp_count, n_errors);
    if (n_errors == 0 && cmp_count > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask
  initial begin
    tick(6000);
    n_errors++;
    wrap_up();
  end
  // ==========================================================================
  // Sequence
  initial begin
    tick(5);
    check_eq({31'h0, arm_lamp_o}, 32'h1);
    check_eq(disp_o.value[31:0], 32'h0);
    tick(1);
    rst_n_i <= 1'h1;
    rd_chk(cdsc_pkg::CTRL_ADDR, 32'hFFFF_FFFF, cdsc_pkg::CTRL_RESET);
    apb(1'h0, 8'h10, 32'h0000_0000);
    check_eq({31'h0, err}, 32'h1);
    power_on_i <= 1'h1;
    tick(8);
    rd_chk(ST, 32'h80, 32'h80);
    tick(60);
    rd_chk(ST, 32'h80, 32'h0);
    oven_fitted_i <= 1'h1;
    oven_cold_i <= 1'h1;
    tick(5);
    check_eq({31'h0, asterisk_o}, 32'h1);
    rd_chk(ST, 32'h11, 32'h11);
    oven_cold_i <= 1'h0;
    tick(5);
    check_eq({31'h0, asterisk_o}, 32'h0);
    for (int i = 0; i < 5; i++) begin
      apb(1'h1, cdsc_pkg::CTRL_ADDR, {20'h0, POS[i], WIN[i], 4'h0});
      rd_chk(ST, 32'h80, 32'h80);
      tick(20);
      rd_chk(ST, 32'h8F, FLG[i]);
    end
    apb(1'h1, cdsc_pkg::CTRL_ADDR, 32'h0040_0700);
    tick(1);
    check_eq({31'h0, ext_ref_sel_o}, 32'h1);
    for (int k = 0; k < 3; k++) begin
      {ref_lost_i, ref_locking_i, reset_btn_i} <= 3'h1 << k;
      tick(6);
      check_eq({31'h0, disp_o.lamp_all}, 32'h1);
      check_eq({31'h0, disp_o.minus & (&disp_o.dp)}, 32'h1);
      {ref_lost_i, ref_locking_i, reset_btn_i} <= 3'h0;
      tick(6);
      check_eq({31'h0, disp_o.lamp_all}, 32'h0);
    end
    apb(1'h1, cdsc_pkg::CTRL_ADDR, 32'h0000_0020);
    tick(20);
    check_eq({31'h0, arm_lamp_o}, 32'h1);
    pulse_a();
    check_eq({30'h0, arm_lamp_o, gate_lamp_o}, 32'h1);
    pulse_a();
    pulse_a();
    tick(3);
    check_eq({31'h0, gate_lamp_o}, 32'h1);
    tick(30);
    check_eq({30'h0, arm_lamp_o, gate_lamp_o}, 32'h0);
    reset_btn_i <= 1'h1;
    tick(5);
    reset_btn_i <= 1'h0;
    tick(20);
    check_eq({31'h0, arm_lamp_o}, 32'h1);
    rd_chk(cdsc_pkg::RESULT_LO_ADDR, 32'hFFFF_FFFF, 32'h0);
    apb(1'h1, cdsc_pkg::CTRL_ADDR, 32'h0000_1020);
    pulse_a();
    pulse_a();
    pulse_a();
    tick(40);
    check_eq({30'h0, arm_lamp_o, gate_lamp_o}, 32'h2);
    apb(1'h1, cdsc_pkg::CTRL_ADDR, 32'h0010_1010);
    check <= 1'h1;
    tick(25);
    check_eq({31'h0, gate_lamp_o}, 32'h1);
    check <= 1'h0;
    apb(1'h1, cdsc_pkg::CTRL_ADDR, 32'h0000_0014);
    tick(25);
    check_eq({31'h0, gate_lamp_o}, 32'h1);
    apb(1'h1, cdsc_pkg::CTRL_ADDR, 32'h0000_0015);
    tick(30);
    check_eq({31'h0, gate_lamp_o}, 32'h0);
    wrap_up();
  end
endmodule // counter_display_status_control_tb
`default_nettype wire
